// *** rtl/cies_pkg.sv ***
package cies_pkg;

    // core widths
    localparam int PC_W = 13;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int SP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int K_W = 11;
    localparam int LATCH_W = 5;
    localparam int WDT_W = 8;
    localparam int PRESC_W = 8;

    // instruction field positions
    localparam int OP4_LSB = 10;
    localparam int OP3_LSB = 11;
    localparam int OP6_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int BSEL_LSB = 7;
    localparam int LATCH_PC_LSB = 3;

    // opcode encodings
    localparam logic [3:0] OP4_SKIP_SET = 4'h7;
    localparam logic [2:0] OP3_CALL = 3'h4;
    localparam logic [5:0] OP6_INVERT = 6'h09;
    localparam logic [5:0] OP6_DECR = 6'h03;
    localparam logic [5:0] OP6_ZERO = 6'h01;
    localparam logic [INSTR_W-1:0] KICK_WORD = 14'h0064;

    // apb map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_ACC = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_PC = 12'h00C;
    localparam logic [APB_AW-1:0] ADDR_STACK = 12'h010;
    localparam logic [APB_AW-1:0] ADDR_FADDR = 12'h014;
    localparam logic [APB_AW-1:0] ADDR_FDATA = 12'h018;
    localparam logic [APB_AW-1:0] ADDR_WDT = 12'h01C;

    // register field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_LATCH_LSB = 8;
    localparam int STATUS_Z_BIT = 0;
    localparam int STATUS_TO_BIT = 1;
    localparam int STATUS_PD_BIT = 2;
    localparam int STATUS_SP_LSB = 8;
    localparam int STATUS_ST_LSB = 12;
    localparam int WDT_PRESC_LSB = 8;

    // reset values
    localparam logic [2:0] FLAGS_RST = 3'h6;
    localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    typedef enum logic [1:0] {ST_EXEC, ST_SKIP_NOP, ST_CALL_NOP} cies_state_e;

    typedef struct packed {
        logic pd;
        logic to;
        logic z;
    } cies_flags_s;

    typedef struct packed {
        logic [2:0] bsel;
        logic dest;
        logic [FADDR_W-1:0] faddr;
    } cies_fields_s;

endpackage

// *** rtl/cies_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module cies_core
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    output logic [cies_pkg::PC_W-1:0] pc_o,
    input wire logic [cies_pkg::INSTR_W-1:0] instr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cies_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output cies_pkg::cies_flags_s flags_o
);
    import cies_pkg::*;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == DATA_ZERO);
    endfunction

    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [DATA_W-1:0] acc_q;
    cies_flags_s flags_q;
    cies_flags_s flags_d;
    cies_state_e st_q;
    cies_state_e st_d;
    logic run_q;
    logic [LATCH_W-1:0] latch_q;
    logic [FADDR_W-1:0] faddr_q;
    logic [SP_W-1:0] sp_q;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [DATA_W-1:0] file_q [FILE_DEPTH];
    logic [WDT_W-1:0] wdt_q;
    logic [PRESC_W-1:0] presc_q;
    logic [31:0] prdata_q;

    // decode
    cies_fields_s fld;
    wire logic [K_W-1:0] kimm;
    wire logic [5:0] op6;
    wire logic exec;
    wire logic exec_skip;
    wire logic exec_call;
    wire logic exec_inv;
    wire logic exec_dec;
    wire logic exec_zero_file;
    wire logic exec_zero_accumulator;
    wire logic exec_kick;
    wire logic alu_en;
    wire logic bit_val;
    wire logic [DATA_W-1:0] fdata;
    wire logic [DATA_W-1:0] alu_res;
    wire logic core_fwr;
    wire logic [DATA_W-1:0] core_fwdata;
    wire logic [PC_W-1:0] pc_inc;
    wire logic [PC_W-1:0] call_target;
    wire logic [PC_W-1:0] stack_top;

    assign fld = {instr_i[BSEL_LSB+2:BSEL_LSB], instr_i[DEST_BIT], instr_i[FADDR_W-1:0]};
    assign kimm = instr_i[K_W-1:0];
    assign op6 = instr_i[INSTR_W-1:OP6_LSB];
    assign exec = run_q && (st_q == ST_EXEC);
    assign exec_skip = exec && (instr_i[INSTR_W-1:OP4_LSB] == OP4_SKIP_SET);
    assign exec_call = exec && (instr_i[INSTR_W-1:OP3_LSB] == OP3_CALL);
    assign exec_inv = exec && (op6 == OP6_INVERT);
    assign exec_dec = exec && (op6 == OP6_DECR);
    assign exec_zero_file = exec && (op6 == OP6_ZERO) && fld.dest;
    assign exec_zero_accumulator = exec && (op6 == OP6_ZERO) && !fld.dest;
    assign exec_kick = exec && (instr_i == KICK_WORD);
    assign alu_en = exec_inv || exec_dec;

    assign fdata = file_q[fld.faddr];
    assign bit_val = fdata[fld.bsel];
    assign alu_res = exec_inv ? ~fdata : fdata - 8'h01;
    assign core_fwr = (alu_en && fld.dest) || exec_zero_file;
    assign core_fwdata = exec_zero_file ? DATA_ZERO : alu_res;

    assign pc_inc = pc_q + 13'h0001;
    assign call_target = {latch_q[LATCH_PC_LSB+1:LATCH_PC_LSB], kimm};
    assign stack_top = stack_q[sp_q - 3'h1];

    // apb slave, zero wait states; read data captured in the setup cycle
    wire logic apb_setup;
    wire logic apb_wr;
    wire logic addr_hit;
    wire logic st_wr;
    wire logic ctrl_wr;
    wire logic faddr_wr;
    wire logic apb_fwr;
    wire logic [31:0] rd_mux;

    assign apb_setup = psel_i && !penable_i;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign addr_hit = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_ACC)
        || (paddr_i == ADDR_PC) || (paddr_i == ADDR_STACK) || (paddr_i == ADDR_FADDR)
        || (paddr_i == ADDR_FDATA) || (paddr_i == ADDR_WDT);
    assign st_wr = apb_wr && (paddr_i == ADDR_STATUS);
    assign ctrl_wr = apb_wr && (paddr_i == ADDR_CTRL);
    assign faddr_wr = apb_wr && (paddr_i == ADDR_FADDR);
    // software may only write the file while the core is stopped
    assign apb_fwr = apb_wr && (paddr_i == ADDR_FDATA) && !run_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

    assign rd_mux = (paddr_i == ADDR_CTRL) ? {19'h0_0000, latch_q, 7'h00, run_q}
        : (paddr_i == ADDR_STATUS) ? {18'h0_0000, st_q, 1'b0, sp_q, 5'h00, flags_q}
        : (paddr_i == ADDR_ACC) ? {24'h00_0000, acc_q}
        : (paddr_i == ADDR_PC) ? {19'h0_0000, pc_q}
        : (paddr_i == ADDR_STACK) ? {19'h0_0000, stack_top}
        : (paddr_i == ADDR_FADDR) ? {25'h000_0000, faddr_q}
        : (paddr_i == ADDR_FDATA) ? {24'h00_0000, file_q[faddr_q]}
        : (paddr_i == ADDR_WDT) ? {16'h0000, presc_q, wdt_q}
        : 32'h0000_0000;

    assign pc_o = pc_q;
    assign flags_o = flags_q;
    assign prdata_o = prdata_q;

    // sequencing
    always_comb
    begin
        pc_d = pc_q;
        st_d = ST_EXEC;
        unique case (st_q)
            ST_EXEC:
            begin
                if (exec_call)
                begin
                    pc_d = call_target;
                    st_d = ST_CALL_NOP;
                end
                else if (exec)
                begin
                    pc_d = pc_inc;
                    if (exec_skip && bit_val)
                    begin
                        st_d = ST_SKIP_NOP;
                    end
                end
            end
            ST_SKIP_NOP:
            begin
                pc_d = pc_inc;
            end
            ST_CALL_NOP:
            begin
                pc_d = pc_q;
            end
        endcase
    end

    // flags: core updates win over a software write in the same cycle
    always_comb
    begin
        flags_d = flags_q;
        if (st_wr)
        begin
            flags_d = {pwdata_i[STATUS_PD_BIT], pwdata_i[STATUS_TO_BIT], pwdata_i[STATUS_Z_BIT]};
        end
        if (alu_en)
        begin
            flags_d.z = is_zero(alu_res);
        end
        if (exec_zero_file || exec_zero_accumulator)
        begin
            flags_d.z = 1'b1;
        end
        if (exec_kick)
        begin
            flags_d.to = 1'b1;
            flags_d.pd = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pc_q <= '0;
            st_q <= ST_EXEC;
            flags_q <= FLAGS_RST;
            run_q <= 1'b0;
            latch_q <= '0;
            faddr_q <= '0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pc_q <= pc_d;
            st_q <= st_d;
            flags_q <= flags_d;
            if (ctrl_wr)
            begin
                run_q <= pwdata_i[CTRL_RUN_BIT];
                latch_q <= pwdata_i[CTRL_LATCH_LSB+LATCH_W-1:CTRL_LATCH_LSB];
            end
            if (faddr_wr)
            begin
                faddr_q <= pwdata_i[FADDR_W-1:0];
            end
            if (apb_setup)
            begin
                prdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            acc_q <= '0;
        end
        else if (exec_zero_accumulator)
        begin
            acc_q <= DATA_ZERO;
        end
        else if (alu_en && !fld.dest)
        begin
            acc_q <= alu_res;
        end
    end

    // circular return stack
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sp_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                stack_q[i] <= '0;
            end
        end
        else if (exec_call)
        begin
            stack_q[sp_q] <= pc_inc;
            sp_q <= sp_q + 3'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < FILE_DEPTH; i++)
            begin
                file_q[i] <= '0;
            end
        end
        else if (core_fwr)
        begin
            file_q[fld.faddr] <= core_fwdata;
        end
        else if (apb_fwr)
        begin
            file_q[faddr_q] <= pwdata_i[DATA_W-1:0];
        end
    end

    // free-running watchdog count; it wraps, and nothing acts on a time-out
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            presc_q <= '0;
            wdt_q <= WDT_CLEAR;
        end
        else if (exec_kick)
        begin
            presc_q <= '0;
            wdt_q <= WDT_CLEAR;
        end
        else
        begin
            presc_q <= presc_q + 8'h01;
            if (&presc_q)
            begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_skip_discard: assert property ((exec_skip && bit_val) |=> (st_q == ST_SKIP_NOP)
        ##1 (st_q == ST_EXEC && pc_q == $past(pc_q, 2) + 13'h0002))
        else $error("skip did not discard the next instruction");
    chk_skip_clear: assert property ((exec_skip && !bit_val) |=> st_q == ST_EXEC)
        else $error("skip with clear bit stalled");
    chk_skip_flags: assert property ((exec_skip && !st_wr) |=> $stable(flags_q))
        else $error("skip altered a status flag");
    chk_kick_clear: assert property (exec_kick |=> (wdt_q == WDT_CLEAR && presc_q == '0
        && flags_q.to && flags_q.pd))
        else $error("watchdog kick did not clear and set flags");
    chk_call_push: assert property (exec_call |=> (stack_top == $past(pc_q) + 13'h0001
        && sp_q == $past(sp_q) + 3'h1))
        else $error("call pushed a wrong return address");
    chk_call_target: assert property (exec_call |=> pc_q == {$past(latch_q[4:3]), $past(kimm)})
        else $error("call loaded a wrong target");
    chk_call_cycles: assert property ((exec_call && !st_wr) |=> (st_q == ST_CALL_NOP
        && $stable(flags_q)) ##1 (st_q == ST_EXEC && $stable(pc_q)))
        else $error("call did not take two cycles");
    chk_invert_dest: assert property ((exec_inv && !fld.dest) |=> acc_q == ~$past(fdata))
        else $error("invert result wrong");
    chk_zero_file: assert property (exec_zero_file |=> (file_q[$past(fld.faddr)] == DATA_ZERO
        && flags_q.z))
        else $error("file clear failed");
    chk_decr_file: assert property ((exec_dec && fld.dest) |=>
        file_q[$past(fld.faddr)] == $past(fdata) - 8'h01)
        else $error("decrement result wrong");
    chk_invert_file: assert property ((exec_inv && fld.dest) |=>
        file_q[$past(fld.faddr)] == ~$past(fdata))
        else $error("invert to file wrong");
    chk_decr_acc: assert property ((exec_dec && !fld.dest) |=> acc_q == $past(fdata) - 8'h01)
        else $error("decrement to accumulator wrong");
    chk_zero_acc: assert property (exec_zero_accumulator |=> (acc_q == DATA_ZERO && flags_q.z))
        else $error("accumulator clear failed");
    chk_zero_flag: assert property (alu_en |=> flags_q.z == ($past(alu_res) == DATA_ZERO))
        else $error("zero flag does not match result");

endmodule

`default_nettype wire

// *** test/cies_progmem.sv ***
`timescale 1ns/1ps
`default_nettype none

module cies_progmem
(
    input wire logic [cies_pkg::PC_W-1:0] pc_i,
    output logic [cies_pkg::INSTR_W-1:0] instr_o
);
    import cies_pkg::*;

    // words never loaded read as zero, which the core runs as a no-op
    logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1] = '{default: 14'h0000};

    // combinational read: the word at the fetch address in the same cycle
    assign instr_o = mem[pc_i];
endmodule

`default_nettype wire

// *** test/cpu_instr_exec_subset_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %s", $time, m); end end

module cpu_instr_exec_subset_bench;
    import cies_pkg::*;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] instr;
    cies_flags_s flags;
    int err_count = 0;
    int check_count = 0;
    logic [31:0] r;
    logic e;

    // program: zero acc, two decrements, invert, taken skip, discarded clear, untaken skip,
    // clear, watchdog kick, invert back to file, call
    logic [13:0] prog [11] = '{14'h0100, 14'h0390, 14'h0315, 14'h0911, 14'h1C91, 14'h0192,
        14'h1D11, 14'h0193, 14'h0064, 14'h0994, 14'h2123};
    logic [2:0] ftab [13] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6};
    logic [7:0] fa [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    logic [7:0] fin [6] = '{8'h05, 8'h5A, 8'h33, 8'h77, 8'h0F, 8'h01};
    logic [7:0] fout [6] = '{8'h04, 8'h5A, 8'h33, 8'h00, 8'hF0, 8'h01};

    always #12.5 mclk = ~mclk;

    cies_core dut
    (
        .mclk_i(mclk),
        .rstn_i(rstn),
        .pc_o(pc),
        .instr_i(instr),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .flags_o(flags)
    );

    cies_progmem pm
    (
        .pc_i(pc),
        .instr_o(instr)
    );

    task test_done;
        if (err_count == 0 && check_count > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one apb transfer; read data and error are taken at the edge where pready is seen
    task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        #500000;
        err_count++;
        test_done();
    end

    initial
    begin
        int i;
        int n;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        for (i = 0; i < 11; i++)
        begin
            pm.mem[i] = prog[i];
        end
        apb(1'b1, ADDR_STATUS, 32'h0000_0000);
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, ADDR_FADDR, {24'h00_0000, fa[i]});
            apb(1'b1, ADDR_FDATA, {24'h00_0000, fin[i]});
        end
        // let the watchdog advance so that the kick has something to clear
        repeat (600) @(posedge mclk);
        apb(1'b0, ADDR_WDT, 32'h0000_0000);
        `CHK(r[7:0] != 8'h00, 1'b1, "watchdog idle")
        apb(1'b1, ADDR_CTRL, 32'h0000_0801);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (pc !== 13'h0001 && n < 20);
        for (i = 0; i < 13; i++)
        begin
            `CHK(pc, (i < 10) ? 13'(i + 1) : ((i == 12) ? 13'h0924 : 13'h0923), "pc trace")
            `CHK(flags, ftab[i], "flag trace")
            @(posedge mclk);
            #1;
        end
        apb(1'b1, ADDR_CTRL, 32'h0000_0800);
        apb(1'b0, ADDR_WDT, 32'h0000_0000);
        `CHK(r[7:0], WDT_CLEAR, "watchdog kick")
        `CHK(r[15:8], 8'h09, "watchdog prescaler")
        apb(1'b1, ADDR_ACC, 32'h0000_00FF);
        apb(1'b0, ADDR_ACC, 32'h0000_0000);
        `CHK(r, 32'h0000_00A5, "accumulator")
        apb(1'b0, ADDR_STACK, 32'h0000_0000);
        `CHK(r, 32'h0000_000B, "stack top")
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(r[10:0], 11'h106, "status")
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, ADDR_FADDR, {24'h00_0000, fa[i]});
            apb(1'b0, ADDR_FDATA, 32'h0000_0000);
            `CHK(r[7:0], fout[i], "file")
        end
        apb(1'b0, 12'h020, 32'h0000_0000);
        `CHK({e, r}, {1'b1, 32'h0000_0000}, "unmapped")
        test_done();
    end
endmodule

`default_nettype wire
